// ==== drive_words_pkg.sv ====
// Package for the drive command and state word block.
// Assumes a single processing clock shared by fieldbus port and drive logic.
package drive_words_pkg;

  // ==========================================================================
  // Word geometry
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SEL_W  = 5;
  localparam int unsigned NUM_SRC = 32;

  // ==========================================================================
  // Command word bit positions
  localparam int unsigned CMD_ON        = 0;
  localparam int unsigned CMD_NO_COAST  = 1;
  localparam int unsigned CMD_NO_QSTOP  = 2;
  localparam int unsigned CMD_ENABLE_OP = 3;
  localparam int unsigned CMD_RFG_EN    = 4;
  localparam int unsigned CMD_RFG_RUN   = 5;
  localparam int unsigned CMD_SP_EN     = 6;
  localparam int unsigned CMD_FAULT_ACK = 7;
  localparam int unsigned CMD_CTRL_PLC  = 10;
  localparam int unsigned CMD_REVERSE   = 11;
  localparam int unsigned CMD_MPOT_UP   = 13;
  localparam int unsigned CMD_MPOT_DOWN = 14;
  localparam logic [15:0] CMD_USED_MASK = 16'h6cff;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  // ==========================================================================
  // Source indices above the sixteen state sources
  localparam logic [4:0] SRC_CMD_BASE = 5'h10;

  // ==========================================================================
  // Reset values of the state word assembly and the setpoint
  localparam logic [79:0] SEL_RESET   = 80'h7b9ac_5a928_398a4_18820;
  localparam logic [15:0] INV_RESET   = 16'ha800;
  localparam logic [15:0] STATE_RESET = 16'h0000;
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;

  typedef enum logic [4:0] {
    SEQ_INHIBIT = 5'h01,
    SEQ_READY   = 5'h02,
    SEQ_RUN_RDY = 5'h04,
    SEQ_ENABLED = 5'h08,
    SEQ_QSTOP   = 5'h10
  } seq_state_t;

  // Drive feedback from the surrounding drive logic
  typedef struct packed {
    logic fault_present;
    logic alarm_present;
    logic speed_in_tol;
    logic control_request;
    logic cmp_reached;
    logic limit_reached;
    logic brake_open;
    logic motor_overtemp;
    logic power_overload;
    logic ramp_at_zero;
    logic speed_negative;
  } drive_feedback_t;

  // Commands to the drive logic
  typedef struct packed {
    logic pulse_enable;
    logic quick_stop_ramp;
    logic rfg_enable;
    logic rfg_hold;
    logic setpoint_zero;
    logic fault_ack;
    logic reverse_req;
    logic mpot_raise;
    logic mpot_lower;
  } drive_command_t;

endpackage : drive_words_pkg

// ==== drive_control_status_words.sv ====
// Command word decode, small switch-on sequence and state word assembly.
// Assumes the fieldbus framing and all drive inputs share core_clk.
//
// Operation
// - Bit 1 low stops pulses at once and enters switch-on-inhibited.
// - Bit 2 low in operation enabled ramps down on quick-stop ramp, then inhibits switching on; in other states it inhibits at once.
// - Bit 3 high permits pulses; low suppresses them except during the quick-stop ramp.
// - Bit 4 low inhibits ramp generator and zeroes its output.
// - Bit 5 low freezes the ramp generator output.
// - Bit 6 low forces the ramp generator input to zero.
// - Bit 7 is routed to fault acknowledgement logic.
// - Process data is accepted only while bit 10 is set.
// - Bit 11 requests direction reversal unless reversal is locked.
// - Bit 13 raises, bit 14 lowers the motorised potentiometer setpoint.
// - State bits 0..2 report ready on, ready for operation, enabled.
// - State bit 4 high without coast stop, bit 5 without quick stop.
// - State bit 6 high while switching on is inhibited.
// - State bit 8 high while speed deviation is within tolerance.
// - State bit 9 high while the drive requests control.
// - State bit 10 high when the comparison value is reached.
// - State bits 11, 13, 15 are inverted from their sources.
// - State bit 12 high while the holding brake is commanded open.
// - State bit 14 high when actual speed is zero or positive.
// - Every state bit has its own source selector and inversion.
`timescale 1ns/100ps
`default_nettype none

module drive_control_status_words (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // Command word from the fieldbus master
  input  wire logic                            cmd_wr,
  input  wire logic [15:0]                     cmd_data,
  output logic      [15:0]                     drive_command_word,
  // Process data (setpoint) from the fieldbus master
  input  wire logic                            pd_wr,
  input  wire logic [15:0]                     pd_data,
  output logic      [15:0]                     setpoint,
  // State word to the fieldbus master
  output logic      [15:0]                     drive_state_word,
  // State word assembly configuration
  input  wire logic                            cfg_wr,
  input  wire logic [79:0]                     cfg_sel,
  input  wire logic [15:0]                     cfg_inv,
  output logic      [79:0]                     state_bit_source_select,
  output logic      [15:0]                     state_bit_inversion,
  // Direction locks
  input  wire logic                            negative_direction_lock,
  input  wire logic                            positive_direction_lock,
  // Drive interface
  input  wire drive_words_pkg::drive_feedback_t fb,
  output drive_words_pkg::drive_command_t      cmd_out,
  output logic                                 switch_on_inhibited
);

  // ==========================================================================
  // Command word capture
  logic [15:0] cmd;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd <= drive_words_pkg::CMD_RESET;
    end else if (cmd_wr) begin
      cmd <= cmd_data & drive_words_pkg::CMD_USED_MASK;
    end
  end

  assign drive_command_word = cmd;

  // Setpoint only follows process data while the master holds control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      setpoint <= drive_words_pkg::SETPOINT_RESET;
    end else if (pd_wr && cmd[drive_words_pkg::CMD_CTRL_PLC]) begin
      setpoint <= pd_data;
    end
  end

  // ==========================================================================
  // Switch-on sequence
  drive_words_pkg::seq_state_t state;
  drive_words_pkg::seq_state_t next_state;

  logic no_coast;
  logic no_qstop;
  logic on_cmd;
  logic op_cmd;

  assign no_coast = cmd[drive_words_pkg::CMD_NO_COAST];
  assign no_qstop = cmd[drive_words_pkg::CMD_NO_QSTOP];
  assign on_cmd   = cmd[drive_words_pkg::CMD_ON];
  assign op_cmd   = cmd[drive_words_pkg::CMD_ENABLE_OP];

  always_comb begin
    next_state = state;
    case (state)
      drive_words_pkg::SEQ_INHIBIT: begin
        // Restart needs the on command dropped first
        if (no_coast && no_qstop && !on_cmd && !fb.fault_present) begin
          next_state = drive_words_pkg::SEQ_READY;
        end
      end
      drive_words_pkg::SEQ_READY: begin
        if (on_cmd) begin
          next_state = drive_words_pkg::SEQ_RUN_RDY;
        end
      end
      drive_words_pkg::SEQ_RUN_RDY: begin
        if (!on_cmd) begin
          next_state = drive_words_pkg::SEQ_READY;
        end else if (op_cmd) begin
          next_state = drive_words_pkg::SEQ_ENABLED;
        end
      end
      drive_words_pkg::SEQ_ENABLED: begin
        if (!op_cmd) begin
          next_state = drive_words_pkg::SEQ_RUN_RDY;
        end else if (!on_cmd) begin
          next_state = drive_words_pkg::SEQ_READY;
        end
      end
      drive_words_pkg::SEQ_QSTOP: begin
        if (fb.ramp_at_zero) begin
          next_state = drive_words_pkg::SEQ_INHIBIT;
        end
      end
      default: begin
        next_state = drive_words_pkg::SEQ_INHIBIT;
      end
    endcase
    // Quick stop only ramps if pulses were running
    if (!no_qstop && state == drive_words_pkg::SEQ_ENABLED) begin
      next_state = drive_words_pkg::SEQ_QSTOP;
    end else if (!no_qstop && state != drive_words_pkg::SEQ_QSTOP) begin
      next_state = drive_words_pkg::SEQ_INHIBIT;
    end
    // Coast stop and faults override everything
    if (!no_coast || fb.fault_present) begin
      next_state = drive_words_pkg::SEQ_INHIBIT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= drive_words_pkg::SEQ_INHIBIT;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Command outputs
  logic rev_locked;

  // Reversal needs the negative sense allowed and is pointless if positive is locked
  assign rev_locked = negative_direction_lock || positive_direction_lock;

  always_comb begin
    cmd_out = '0;
    // Coast stop gates pulses without waiting a cycle for the state
    cmd_out.pulse_enable    = no_coast && (state == drive_words_pkg::SEQ_ENABLED ||
                              state == drive_words_pkg::SEQ_QSTOP) &&
                              !fb.fault_present;
    cmd_out.quick_stop_ramp = state == drive_words_pkg::SEQ_QSTOP;
    cmd_out.rfg_enable      = cmd[drive_words_pkg::CMD_RFG_EN];
    cmd_out.rfg_hold        = !cmd[drive_words_pkg::CMD_RFG_RUN];
    cmd_out.setpoint_zero   = !cmd[drive_words_pkg::CMD_SP_EN];
    cmd_out.fault_ack       = cmd[drive_words_pkg::CMD_FAULT_ACK];
    cmd_out.reverse_req     = cmd[drive_words_pkg::CMD_REVERSE] && !rev_locked;
    cmd_out.mpot_raise      = cmd[drive_words_pkg::CMD_MPOT_UP];
    cmd_out.mpot_lower      = cmd[drive_words_pkg::CMD_MPOT_DOWN];
  end

  assign switch_on_inhibited = state == drive_words_pkg::SEQ_INHIBIT;

  // ==========================================================================
  // State word configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_bit_source_select <= drive_words_pkg::SEL_RESET;
      state_bit_inversion     <= drive_words_pkg::INV_RESET;
    end else if (cfg_wr) begin
      state_bit_source_select <= cfg_sel;
      state_bit_inversion     <= cfg_inv;
    end
  end

  // ==========================================================================
  // State word assembly
  logic [drive_words_pkg::NUM_SRC-1:0] src;
  logic [15:0] next_word;

  function automatic logic [4:0] sel_of(input logic [79:0] sel, input int unsigned idx);
    sel_of = sel[idx*drive_words_pkg::SEL_W +: drive_words_pkg::SEL_W];
  endfunction : sel_of

  always_comb begin
    src[0]  = state == drive_words_pkg::SEQ_READY ||
              state == drive_words_pkg::SEQ_RUN_RDY ||
              state == drive_words_pkg::SEQ_ENABLED;
    src[1]  = state == drive_words_pkg::SEQ_RUN_RDY ||
              state == drive_words_pkg::SEQ_ENABLED;
    src[2]  = state == drive_words_pkg::SEQ_ENABLED;
    src[3]  = fb.fault_present;
    src[4]  = no_coast;
    src[5]  = no_qstop && state != drive_words_pkg::SEQ_QSTOP;
    src[6]  = state == drive_words_pkg::SEQ_INHIBIT;
    src[7]  = fb.alarm_present;
    src[8]  = fb.speed_in_tol;
    src[9]  = fb.control_request;
    src[10] = fb.cmp_reached;
    src[11] = fb.limit_reached;
    src[12] = fb.brake_open;
    src[13] = fb.motor_overtemp;
    src[14] = !fb.speed_negative;
    src[15] = fb.power_overload;
    // Upper sources echo the command word, useful for loopback checks
    src[31:16] = cmd;
  end

  always_comb begin
    next_word = '0;
    for (int unsigned i = 0; i < drive_words_pkg::WORD_W; i++) begin
      next_word[i] = src[sel_of(state_bit_source_select, i)]
                     ^ state_bit_inversion[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_state_word <= drive_words_pkg::STATE_RESET;
    end else begin
      drive_state_word <= next_word;
    end
  end

  // ==========================================================================
  // Checks
  logic cfg_default;

  assign cfg_default = state_bit_source_select == drive_words_pkg::SEL_RESET &&
                       state_bit_inversion == drive_words_pkg::INV_RESET;

  chk_coast_stop_off: assert property (@(posedge core_clk) disable iff (rst)
    !no_coast |-> !cmd_out.pulse_enable ##1 state == drive_words_pkg::SEQ_INHIBIT)
    else $error("coast stop did not stop pulses and inhibit");

  chk_quick_stop_ramp: assert property (@(posedge core_clk) disable iff (rst)
    state == drive_words_pkg::SEQ_ENABLED && !no_qstop && no_coast && !fb.fault_present
    |=> state == drive_words_pkg::SEQ_QSTOP && cmd_out.quick_stop_ramp)
    else $error("quick stop did not start the ramp");

  chk_enable_gate: assert property (@(posedge core_clk) disable iff (rst)
    state == drive_words_pkg::SEQ_ENABLED |-> $past(op_cmd))
    else $error("operation enabled without enable bit");

  chk_rfg_inhibit: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && !cmd_data[drive_words_pkg::CMD_RFG_EN] |=> !cmd_out.rfg_enable)
    else $error("ramp generator not inhibited");

  chk_rfg_freeze: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && !cmd_data[drive_words_pkg::CMD_RFG_RUN] |=> cmd_out.rfg_hold)
    else $error("ramp generator not frozen");

  chk_setpoint_zero: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && !cmd_data[drive_words_pkg::CMD_SP_EN] |=> cmd_out.setpoint_zero)
    else $error("setpoint not inhibited");

  chk_fault_ack: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && cmd_data[drive_words_pkg::CMD_FAULT_ACK] |=> cmd_out.fault_ack)
    else $error("fault acknowledge not routed");

  chk_pd_ignored: assert property (@(posedge core_clk) disable iff (rst)
    pd_wr && !cmd[drive_words_pkg::CMD_CTRL_PLC] |=> $stable(setpoint))
    else $error("process data taken without control bit");

  chk_reverse_lock: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && cmd_data[drive_words_pkg::CMD_REVERSE] && !rev_locked
    ##1 !rev_locked |-> cmd_out.reverse_req)
    else $error("reversal request lost");

  chk_mpot_cmd: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr |=> cmd_out.mpot_raise == $past(cmd_data[drive_words_pkg::CMD_MPOT_UP]) &&
               cmd_out.mpot_lower == $past(cmd_data[drive_words_pkg::CMD_MPOT_DOWN]))
    else $error("potentiometer command wrong");

  chk_state_enabled: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && state == drive_words_pkg::SEQ_ENABLED
    |=> drive_state_word[2:0] == 3'h7)
    else $error("enabled state not reported");

  chk_coast_report: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && !no_coast |=> !drive_state_word[4])
    else $error("coast stop not reported");

  chk_inhibit_report: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && state == drive_words_pkg::SEQ_INHIBIT |=> drive_state_word[6])
    else $error("switch-on inhibit not reported");

  chk_limit_inverted: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && fb.limit_reached |=> !drive_state_word[11])
    else $error("limit bit not inverted");

  chk_speed_sign: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[14] == !$past(fb.speed_negative))
    else $error("speed sign bit wrong");

  chk_qstop_report: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && !no_qstop |=> !drive_state_word[5])
    else $error("quick stop not reported");

  chk_ready_report: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default && state == drive_words_pkg::SEQ_READY |=> drive_state_word[2:0] == 3'h1)
    else $error("ready state not reported");

  chk_fault_report: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[3] == $past(fb.fault_present) &&
                    drive_state_word[7] == $past(fb.alarm_present))
    else $error("fault or alarm bit wrong");

  chk_speed_tol: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[8] == $past(fb.speed_in_tol))
    else $error("speed tolerance bit wrong");

  chk_control_request: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[9] == $past(fb.control_request))
    else $error("control request bit wrong");

  chk_compare_reached: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[10] == $past(fb.cmp_reached))
    else $error("comparison bit wrong");

  chk_brake_open: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[12] == $past(fb.brake_open))
    else $error("brake bit wrong");

  chk_alarm_inverted: assert property (@(posedge core_clk) disable iff (rst)
    cfg_default |=> drive_state_word[13] == !$past(fb.motor_overtemp) &&
                    drive_state_word[15] == !$past(fb.power_overload))
    else $error("thermal alarm bits not inverted");

  chk_unused_bits: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr |=> (drive_command_word & ~drive_words_pkg::CMD_USED_MASK) == 16'h0000)
    else $error("unused command bits stored");

endmodule : drive_control_status_words

`default_nettype wire

// ==== fieldbus_master_model.sv ====
// Fieldbus master model: command word, process data and state word setup.
// Assumes the bench calls its tasks; all outputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none

module fieldbus_master_model (
  // Clock
  input  wire logic        core_clk,
  // Command word and process data
  output logic             cmd_wr,
  output logic [15:0]      cmd_data,
  output logic             pd_wr,
  output logic [15:0]      pd_data,
  // State word configuration
  output logic             cfg_wr,
  output logic [79:0]      cfg_sel,
  output logic [15:0]      cfg_inv
);
  logic [15:0] last_cmd;

  initial begin
    cmd_wr   = 1'b0;
    cmd_data = 16'h0000;
    pd_wr    = 1'b0;
    pd_data  = 16'h0000;
    cfg_wr   = 1'b0;
    cfg_sel  = 80'h0;
    cfg_inv  = 16'h0000;
    last_cmd = 16'h0000;
  end

  // ==========================================================================
  // Transfers
  task automatic write_cmd(input logic [15:0] w);
    @(negedge core_clk);
    cmd_wr   = 1'b1;
    cmd_data = w;
    @(negedge core_clk);
    cmd_wr   = 1'b0;
    // Released lines never keep the last value
    cmd_data = ~w;
    last_cmd = w;
  endtask : write_cmd

  // keep=0 lets a scenario send data while acceptance is off
  task automatic write_pd(input logic [15:0] w, input logic keep);
    if (keep && !last_cmd[10]) write_cmd(last_cmd | 16'h0400);
    @(negedge core_clk);
    pd_wr   = 1'b1;
    pd_data = w;
    @(negedge core_clk);
    pd_wr   = 1'b0;
    pd_data = ~w;
  endtask : write_pd

  task automatic write_cfg(input logic [79:0] sel, input logic [15:0] inv);
    @(negedge core_clk);
    cfg_wr  = 1'b1;
    cfg_sel = sel;
    cfg_inv = inv;
    @(negedge core_clk);
    cfg_wr  = 1'b0;
    cfg_sel = ~sel;
    cfg_inv = ~inv;
  endtask : write_cfg

  task automatic ack_faults();
    write_cmd(last_cmd | 16'h0080);
    write_cmd(last_cmd & 16'hff7f);
  endtask : ack_faults
endmodule : fieldbus_master_model
`default_nettype wire

// ==== test_drive_control_status_words.sv ====
// Self-checking bench for the command and state word block.
// Assumes the master model drives all fieldbus inputs of the block.
`timescale 1ns/100ps
`default_nettype none

module test_drive_control_status_words;
  logic                            core_clk, rst, cmd_wr, pd_wr, cfg_wr;
  logic [15:0]                     cmd_data, pd_data, drive_command_word, setpoint;
  logic [15:0]                     drive_state_word, cfg_inv, state_bit_inversion;
  logic [79:0]                     cfg_sel, state_bit_source_select, sel;
  logic                            negative_direction_lock, positive_direction_lock;
  logic                            switch_on_inhibited;
  drive_words_pkg::drive_feedback_t fb;
  drive_words_pkg::drive_command_t  cmd_out;
  int                              errors, total_checks;
  logic [15:0]                     fb_mask [11] = '{16'h4000, 16'h0000, 16'h8000, 16'h2000,
    16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0008};

  fieldbus_master_model fieldbus_master_model_i (.core_clk(core_clk), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .pd_wr(pd_wr), .pd_data(pd_data), .cfg_wr(cfg_wr),
    .cfg_sel(cfg_sel), .cfg_inv(cfg_inv));

  drive_control_status_words drive_control_status_words_i (.core_clk(core_clk), .rst(rst),
    .cmd_wr(cmd_wr), .cmd_data(cmd_data), .drive_command_word(drive_command_word),
    .pd_wr(pd_wr), .pd_data(pd_data), .setpoint(setpoint),
    .drive_state_word(drive_state_word), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_inv(cfg_inv), .state_bit_source_select(state_bit_source_select),
    .state_bit_inversion(state_bit_inversion),
    .negative_direction_lock(negative_direction_lock),
    .positive_direction_lock(positive_direction_lock), .fb(fb), .cmd_out(cmd_out),
    .switch_on_inhibited(switch_on_inhibited));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Helpers
  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  // State word lags a command by one state step plus one register
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask : settle

  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    fb  = '0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    fieldbus_master_model_i.last_cmd = 16'h0000;
  endtask : do_reset

  task automatic step(input logic [15:0] w, input logic [15:0] exp);
    fieldbus_master_model_i.write_cmd(w);
    settle();
    check16(drive_state_word, exp);
  endtask : step

  function automatic logic [8:0] exp_cmd(input logic [15:0] w, input logic lk);
    exp_cmd = {2'b00, w[4], ~w[5], ~w[6], w[7], w[11] & ~lk, w[13], w[14]};
  endfunction : exp_cmd

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    do_reset();
    @(negedge core_clk);
    check16(drive_command_word, 16'h0000);
    check16(setpoint, 16'h0000);
    check16(16'(cmd_out), 16'h0030);
    check16(state_bit_inversion, drive_words_pkg::INV_RESET);
    if (state_bit_source_select !== drive_words_pkg::SEL_RESET) check16(16'h0001, 16'h0000);
    settle();
    check16(drive_state_word, 16'he840);
  endtask : t_reset_values

  task automatic t_cmd_bits();
    logic [15:0] w;
    do_reset();
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      fieldbus_master_model_i.write_cmd(w);
      check16(drive_command_word, w & drive_words_pkg::CMD_USED_MASK);
      check16(16'(cmd_out), 16'(exp_cmd(w, 1'b0)));
    end
    fieldbus_master_model_i.write_cmd(16'h0800);
    for (int k = 0; k < 4; k++) begin
      {positive_direction_lock, negative_direction_lock} = 2'(k);
      @(negedge core_clk);
      check16(16'(cmd_out.reverse_req), 16'(k == 0));
    end
    {positive_direction_lock, negative_direction_lock} = 2'b00;
  endtask : t_cmd_bits

  task automatic t_sequence();
    do_reset();
    step(16'h0006, 16'he831);
    step(16'h0007, 16'he833);
    step(16'h000f, 16'he837);
    check16(16'(cmd_out.pulse_enable), 16'h0001);
    step(16'h0007, 16'he833);
    check16(16'(cmd_out.pulse_enable), 16'h0000);
    step(16'h000f, 16'he837);
    fieldbus_master_model_i.write_cmd(16'h000d);
    check16(16'(cmd_out.pulse_enable), 16'h0000);
    settle();
    check16(16'(switch_on_inhibited), 16'h0001);
    check16(drive_state_word, 16'he860);
  endtask : t_sequence

  task automatic t_quick_stop();
    int n;
    do_reset();
    step(16'h0006, 16'he831);
    step(16'h0007, 16'he833);
    step(16'h000f, 16'he837);
    fieldbus_master_model_i.write_cmd(16'h000b);
    settle();
    check16(16'({cmd_out.pulse_enable, cmd_out.quick_stop_ramp}), 16'h0003);
    check16(drive_state_word & 16'h0070, 16'h0010);
    fb.ramp_at_zero = 1'b1;
    for (n = 0; n < 20 && switch_on_inhibited !== 1'b1; n++) @(negedge core_clk);
    if (n == 20) begin
      check16(16'(switch_on_inhibited), 16'h0001);
      final_report();
    end
    check16(16'(cmd_out.pulse_enable), 16'h0000);
    settle();
    check16(drive_state_word & 16'h0040, 16'h0040);
  endtask : t_quick_stop

  task automatic t_process_data();
    do_reset();
    fieldbus_master_model_i.write_pd(16'h1234, 1'b0);
    check16(setpoint, 16'h0000);
    fieldbus_master_model_i.write_pd(16'h5a5a, 1'b1);
    check16(setpoint, 16'h5a5a);
    fieldbus_master_model_i.write_pd(16'ha5a5, 1'b1);
    check16(setpoint, 16'ha5a5);
  endtask : t_process_data

  task automatic t_feedback();
    do_reset();
    for (int j = 0; j < 11; j++) begin
      fb = drive_words_pkg::drive_feedback_t'(11'h001 << j);
      settle();
      check16(drive_state_word, 16'he840 ^ fb_mask[j]);
    end
    fb = '0;
    fieldbus_master_model_i.ack_faults();
    step(16'h0006, 16'he831);
    step(16'h0002, 16'he850);
  endtask : t_feedback

  task automatic t_config();
    do_reset();
    sel      = drive_words_pkg::SEL_RESET;
    sel[4:0] = drive_words_pkg::SRC_CMD_BASE | 5'h03;
    fieldbus_master_model_i.write_cfg(sel, drive_words_pkg::INV_RESET | 16'h0001);
    check16(state_bit_inversion, 16'ha801);
    if (state_bit_source_select !== sel) check16(16'h0001, 16'h0000);
    settle();
    check16(drive_state_word, 16'he841);
    fieldbus_master_model_i.write_cmd(16'h0008);
    settle();
    check16(drive_state_word, 16'he840);
  endtask : t_config

  // ==========================================================================
  // Main sequence
  initial begin
    rst                     = 1'b1;
    fb                      = '0;
    negative_direction_lock = 1'b0;
    positive_direction_lock = 1'b0;
    errors                  = 0;
    total_checks            = 0;
    t_reset_values();
    t_cmd_bits();
    t_sequence();
    t_quick_stop();
    t_process_data();
    t_feedback();
    t_config();
    final_report();
  end
endmodule : test_drive_control_status_words
`default_nettype wire
